// File: cmc_pkg.sv
package cmc_pkg;
  localparam int BSEL_MODE_BIT = 3;
  localparam int BSEL_BANK_BIT = 0;
  localparam logic [3:0] BSEL_RESET = 4'h8;
  localparam logic [11:0] BSEL_ADDR = 12'hFC0;
  localparam logic [11:0] DM_RAM_LO = 12'h000;
  localparam logic [11:0] DM_RAM_HI = 12'h1FF;
  localparam logic [11:0] DM_PER_LO = 12'hF80;
  localparam logic [11:0] DM_PER_HI = 12'hFFF;
  localparam int PM_AW = 13;
  localparam int PM_WORDS = 8192;
  localparam logic [12:0] PM_RST_VEC = 13'h0000;
  localparam logic [12:0] PM_IRQ_VEC = 13'h0002;
  localparam logic [12:0] PM_IRQ_LAST = 13'h000D;
  localparam logic [12:0] PM_TBL_LO = 13'h0020;
  localparam logic [12:0] PM_TBL_HI = 13'h007F;
  localparam logic [2:0] IRQ_LAST = 3'h5;
  localparam int VEC_MEM_EN_BIT = 7;
  localparam int VEC_REG_EN_BIT = 6;
  localparam logic [1:0] STK_LEGACY = 2'h2;
  localparam logic [1:0] STK_EXT = 2'h3;
  localparam logic [2:0] CYC_CALL_LEG = 3'h3;
  localparam logic [2:0] CYC_CALL_EXT = 3'h4;
  localparam logic [2:0] CYC_FCALL_LEG = 3'h2;
  localparam logic [2:0] CYC_FCALL_EXT = 3'h3;
  localparam logic [2:0] CYC_BR_FAR = 3'h3;
  localparam logic [2:0] CYC_CALL_FAR = 3'h4;
  localparam logic [2:0] CYC_RET = 3'h3;
  localparam logic [2:0] CYC_TBL = 3'h1;

  typedef enum logic [2:0] {
    OP_CALL_ABS, OP_CALL_FIX, OP_BR_FAR, OP_CALL_FAR, OP_RET, OP_TBL
  } cmc_op_t;

  function automatic logic [2:0] cmc_cycles(input logic [2:0] op,
                                            input logic legacy);
    unique case (op)
      OP_CALL_ABS: cmc_cycles = legacy ? CYC_CALL_LEG : CYC_CALL_EXT;
      OP_CALL_FIX: cmc_cycles = legacy ? CYC_FCALL_LEG : CYC_FCALL_EXT;
      OP_BR_FAR: cmc_cycles = CYC_BR_FAR;
      OP_CALL_FAR: cmc_cycles = CYC_CALL_FAR;
      OP_RET: cmc_cycles = CYC_RET;
      OP_TBL: cmc_cycles = CYC_TBL;
      default: cmc_cycles = 3'h0;
    endcase
  endfunction : cmc_cycles

  function automatic logic cmc_is_call(input logic [2:0] op);
    cmc_is_call = (op == OP_CALL_ABS) || (op == OP_CALL_FIX) ||
                  (op == OP_CALL_FAR);
  endfunction : cmc_is_call

  function automatic logic cmc_in_range(input logic [12:0] a,
                                        input logic [12:0] lo,
                                        input logic [12:0] hi);
    cmc_in_range = (a >= lo) && (a <= hi);
  endfunction : cmc_in_range
endpackage : cmc_pkg

// File: cmc_dm_if.sv
`timescale 1ns/1ps
interface cmc_dm_if;
  logic [11:0] addr;
  logic wr;
  logic [3:0] wdata;
  logic ram_sel;
  logic per_sel;
  logic sel_hit;
  logic [3:0] bank_sel;
  modport core (output addr, wr, wdata,
                input ram_sel, per_sel, sel_hit, bank_sel);
  modport dec (input addr, output ram_sel, per_sel, sel_hit);
  modport regs (input wr, wdata, sel_hit, output bank_sel);
endinterface : cmc_dm_if

// File: cmc_addr_dec.sv
`timescale 1ns/1ps
module cmc_addr_dec (
  cmc_dm_if.dec dm
);
  assign dm.ram_sel = cmc_pkg::cmc_in_range({1'b0, dm.addr},
    {1'b0, cmc_pkg::DM_RAM_LO}, {1'b0, cmc_pkg::DM_RAM_HI});
  assign dm.per_sel = cmc_pkg::cmc_in_range({1'b0, dm.addr},
    {1'b0, cmc_pkg::DM_PER_LO}, {1'b0, cmc_pkg::DM_PER_HI});
  assign dm.sel_hit = (dm.addr == cmc_pkg::BSEL_ADDR);
endmodule : cmc_addr_dec

// File: cmc_sbs_reg.sv
`timescale 1ns/1ps
module cmc_bsel_reg (
  input wire logic mclk,
  input wire logic arst_n,
  cmc_dm_if.regs dm
);
  logic [3:0] bsel_reg;
  logic seen_reg;
  wire wr_hit = dm.wr && dm.sel_hit;

  // Whole nibble at once, no bit writes
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bsel_reg <= cmc_pkg::BSEL_RESET;
      seen_reg <= 1'b0;
    end
    else
    begin
      if (wr_hit)
        bsel_reg <= dm.wdata;
      seen_reg <= 1'b1;
    end
  end

  assign dm.bank_sel = bsel_reg;

  property p_bsel_reset;
    @(posedge mclk) disable iff (!arst_n)
    !seen_reg |-> bsel_reg == cmc_pkg::BSEL_RESET;
  endproperty
  a_bsel_reset: assert property (p_bsel_reset)
    else $error("mode register not in legacy after reset");

  property p_bsel_write;
    @(posedge mclk) disable iff (!arst_n)
    wr_hit |=> bsel_reg == $past(dm.wdata);
  endproperty
  a_bsel_write: assert property (p_bsel_write)
    else $error("nibble write not stored whole");

  property p_bsel_hold;
    @(posedge mclk) disable iff (!arst_n)
    !wr_hit |=> $stable(bsel_reg);
  endproperty
  a_bsel_hold: assert property (p_bsel_hold)
    else $error("mode register changed without a write");
endmodule : cmc_bsel_reg

// File: cmc_core.sv
`timescale 1ns/1ps
module cmc_core #(
  parameter int PM_WORDS = cmc_pkg::PM_WORDS
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [11:0] dm_addr,
  input wire logic dm_wr,
  input wire logic [3:0] dm_wdata,
  output logic [3:0] dm_rdata,
  output logic dm_ram_sel,
  output logic dm_periph_sel,
  input wire logic op_valid,
  input wire logic [2:0] op_code,
  input wire logic [12:0] op_target,
  input wire logic irq_req,
  input wire logic [2:0] irq_num,
  input wire logic [7:0] pm_rdata,
  output logic op_ready,
  output logic op_busy,
  output logic op_done,
  output logic op_fault,
  output logic [1:0] push_bytes,
  output logic legacy_mode,
  output logic stack_bank,
  output logic [12:0] pm_addr,
  output logic start_valid,
  output logic [12:0] start_pc,
  output logic start_reg_bank_en,
  output logic start_mem_bank_en,
  output logic tbl_valid,
  output logic [15:0] tbl_entry
);
  typedef enum {ST_FETCH0, ST_FETCH1, ST_IDLE, ST_EXEC} cmc_state_t;
  typedef enum {K_RST, K_IRQ, K_TBL} cmc_kind_t;

  //////////////////////////////////////////////////////////////////////
  // Data memory side
  cmc_dm_if dm();
  assign dm.addr = dm_addr;
  assign dm.wr = dm_wr;
  assign dm.wdata = dm_wdata;

  cmc_addr_dec u_dec (
    .dm(dm)
  );

  cmc_bsel_reg u_bsel (
    .mclk(mclk),
    .arst_n(arst_n),
    .dm(dm)
  );

  logic [3:0] rdata_reg;
  logic ram_sel_reg;
  logic per_sel_reg;
  wire [3:0] rdata_next = dm.sel_hit ? dm.bank_sel : 4'h0;

  // Mode and bank come straight from the register flops
  wire legacy = dm.bank_sel[cmc_pkg::BSEL_MODE_BIT];
  assign legacy_mode = legacy;
  assign stack_bank = dm.bank_sel[cmc_pkg::BSEL_BANK_BIT];

  //////////////////////////////////////////////////////////////////////
  // Instruction control
  cmc_state_t state_reg, state_next;
  cmc_kind_t kind_reg, kind_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [2:0] opk_reg, opk_next;
  logic mleg_reg, mleg_next;
  logic [12:0] tgt_reg, tgt_next;
  logic [12:0] pm_addr_reg, pm_next;
  logic [7:0] hi_reg, hi_next;
  logic ready_reg, busy_reg, done_reg, fault_reg;
  logic [1:0] push_reg, push_next;
  logic start_reg, tbl_reg;
  logic [12:0] start_pc_reg;
  logic reg_en_reg, mem_en_reg;
  logic [15:0] entry_reg;

  wire [2:0] cyc = cmc_pkg::cmc_cycles(op_code, legacy);
  wire is_far = (op_code == cmc_pkg::OP_BR_FAR) ||
                (op_code == cmc_pkg::OP_CALL_FAR);
  wire is_tbl = (op_code == cmc_pkg::OP_TBL);
  wire tbl_ok = cmc_pkg::cmc_in_range(op_target, cmc_pkg::PM_TBL_LO,
                                      cmc_pkg::PM_TBL_HI);
  wire pm_ok = 32'(op_target) < PM_WORDS;
  wire op_bad = (is_far && legacy) || (is_tbl && !tbl_ok) ||
                !pm_ok || (cyc == 3'h0);
  wire idle = (state_reg == ST_IDLE);
  wire irq_take = idle && irq_req && (irq_num <= cmc_pkg::IRQ_LAST);
  wire op_take = idle && !irq_take && op_valid && ready_reg;
  wire op_go = op_take && !op_bad;
  wire [12:0] irq_vec = cmc_pkg::PM_IRQ_VEC + {9'h000, irq_num, 1'b0};
  wire exec_end = (state_reg == ST_EXEC) && (cnt_reg == 3'h0);
  wire fetch_end = (state_reg == ST_FETCH1);
  wire tbl_end = fetch_end && (kind_reg == K_TBL);
  wire opk_tbl = (opk_reg == cmc_pkg::OP_TBL);

  always_comb
  begin
    state_next = state_reg;
    kind_next = kind_reg;
    cnt_next = cnt_reg;
    opk_next = opk_reg;
    mleg_next = mleg_reg;
    tgt_next = tgt_reg;
    pm_next = pm_addr_reg;
    hi_next = hi_reg;
    push_next = 2'h0;
    unique case (state_reg)
      ST_FETCH0:
      begin
        hi_next = pm_rdata;
        pm_next = pm_addr_reg + 13'h0001;
        state_next = ST_FETCH1;
      end
      ST_FETCH1:
        state_next = ST_IDLE;
      ST_IDLE:
      begin
        if (irq_take)
        begin
          pm_next = irq_vec;
          kind_next = K_IRQ;
          state_next = ST_FETCH0;
        end
        else if (op_go)
        begin
          // Mode is caught here, so a finished write counts
          cnt_next = cyc - 3'h1;
          opk_next = op_code;
          mleg_next = legacy;
          tgt_next = op_target;
          state_next = ST_EXEC;
        end
      end
      ST_EXEC:
      begin
        if (cnt_reg != 3'h0)
          cnt_next = cnt_reg - 3'h1;
        else if (opk_tbl)
        begin
          pm_next = tgt_reg;
          kind_next = K_TBL;
          state_next = ST_FETCH0;
        end
        else
        begin
          state_next = ST_IDLE;
          if (cmc_pkg::cmc_is_call(opk_reg))
            push_next = mleg_reg ? cmc_pkg::STK_LEGACY
                                 : cmc_pkg::STK_EXT;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= ST_FETCH0;
      kind_reg <= K_RST;
      cnt_reg <= 3'h0;
      opk_reg <= 3'h0;
      mleg_reg <= 1'b1;
      tgt_reg <= 13'h0000;
      pm_addr_reg <= cmc_pkg::PM_RST_VEC;
      hi_reg <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      cnt_reg <= cnt_next;
      opk_reg <= opk_next;
      mleg_reg <= mleg_next;
      tgt_reg <= tgt_next;
      pm_addr_reg <= pm_next;
      hi_reg <= hi_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Output flops
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_reg <= 4'h0;
      ram_sel_reg <= 1'b0;
      per_sel_reg <= 1'b0;
      ready_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      fault_reg <= 1'b0;
      push_reg <= 2'h0;
      start_reg <= 1'b0;
      start_pc_reg <= 13'h0000;
      reg_en_reg <= 1'b0;
      mem_en_reg <= 1'b0;
      tbl_reg <= 1'b0;
      entry_reg <= 16'h0000;
    end
    else
    begin
      rdata_reg <= rdata_next;
      ram_sel_reg <= dm.ram_sel;
      per_sel_reg <= dm.per_sel;
      ready_reg <= (state_next == ST_IDLE);
      busy_reg <= (state_next == ST_EXEC);
      done_reg <= (exec_end && !opk_tbl) || tbl_end;
      fault_reg <= op_take && op_bad;
      push_reg <= push_next;
      start_reg <= fetch_end && !tbl_end;
      tbl_reg <= tbl_end;
      if (fetch_end && !tbl_end)
      begin
        start_pc_reg <= {hi_reg[4:0], pm_rdata};
        reg_en_reg <= hi_reg[cmc_pkg::VEC_REG_EN_BIT];
        mem_en_reg <= hi_reg[cmc_pkg::VEC_MEM_EN_BIT];
      end
      if (tbl_end)
        entry_reg <= {hi_reg, pm_rdata};
    end
  end

  assign dm_rdata = rdata_reg;
  assign dm_ram_sel = ram_sel_reg;
  assign dm_periph_sel = per_sel_reg;
  assign op_ready = ready_reg;
  assign op_busy = busy_reg;
  assign op_done = done_reg;
  assign op_fault = fault_reg;
  assign push_bytes = push_reg;
  assign pm_addr = pm_addr_reg;
  assign start_valid = start_reg;
  assign start_pc = start_pc_reg;
  assign start_reg_bank_en = reg_en_reg;
  assign start_mem_bank_en = mem_en_reg;
  assign tbl_valid = tbl_reg;
  assign tbl_entry = entry_reg;

  //////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  property p_far_legacy;
    op_take && is_far && legacy |=> op_fault && !op_busy;
  endproperty
  a_far_legacy: assert property (p_far_legacy)
    else $error("far instruction ran in legacy mode");

  property p_call_abs_leg;
    op_go && op_code == cmc_pkg::OP_CALL_ABS && legacy |=>
      op_busy [*3] ##1 (op_done && push_bytes == cmc_pkg::STK_LEGACY);
  endproperty
  a_call_abs_leg: assert property (p_call_abs_leg)
    else $error("legacy absolute call not three cycles");

  property p_call_abs_ext;
    op_go && op_code == cmc_pkg::OP_CALL_ABS && !legacy |=>
      op_busy [*4] ##1 op_done;
  endproperty
  a_call_abs_ext: assert property (p_call_abs_ext)
    else $error("extended absolute call not four cycles");

  property p_fcall_leg;
    op_go && op_code == cmc_pkg::OP_CALL_FIX && legacy |=>
      op_busy [*2] ##1 op_done;
  endproperty
  a_fcall_leg: assert property (p_fcall_leg)
    else $error("legacy fixed call not two cycles");

  property p_fcall_ext;
    op_go && op_code == cmc_pkg::OP_CALL_FIX && !legacy |=>
      op_busy [*3] ##1 op_done;
  endproperty
  a_fcall_ext: assert property (p_fcall_ext)
    else $error("extended fixed call not three cycles");

  property p_push_ext;
    op_go && op_code == cmc_pkg::OP_CALL_FAR |=>
      op_busy [*4] ##1 (op_done && push_bytes == cmc_pkg::STK_EXT);
  endproperty
  a_push_ext: assert property (p_push_ext)
    else $error("extended call frame not three bytes");

  property p_tbl_range;
    op_take && is_tbl && !tbl_ok |=> op_fault && !op_busy;
  endproperty
  a_tbl_range: assert property (p_tbl_range)
    else $error("table entry outside table area accepted");

  property p_rst_fetch;
    start_valid && kind_reg == K_RST |->
      $past(pm_addr, 2) == cmc_pkg::PM_RST_VEC &&
      $past(pm_addr) == cmc_pkg::PM_RST_VEC + 13'h0001;
  endproperty
  a_rst_fetch: assert property (p_rst_fetch)
    else $error("reset vector not fetched from first words");

  property p_irq_fetch;
    irq_take |=> pm_addr == $past(irq_vec) &&
      pm_addr <= cmc_pkg::PM_IRQ_LAST ##2 start_valid;
  endproperty
  a_irq_fetch: assert property (p_irq_fetch)
    else $error("interrupt vector fetch wrong");

  property p_tbl_entry;
    tbl_end |=> tbl_valid && op_done &&
      tbl_entry == {$past(hi_reg), $past(pm_rdata)};
  endproperty
  a_tbl_entry: assert property (p_tbl_entry)
    else $error("table entry not delivered");

  property p_ram_area;
    dm_ram_sel |-> $past(dm_addr) <= cmc_pkg::DM_RAM_HI;
  endproperty
  a_ram_area: assert property (p_ram_area)
    else $error("RAM select outside data area");

  property p_per_area;
    dm_periph_sel |-> $past(dm_addr) >= cmc_pkg::DM_PER_LO;
  endproperty
  a_per_area: assert property (p_per_area)
    else $error("peripheral select outside its area");

  property p_mode_next;
    dm_wr && dm.sel_hit |=>
      legacy_mode == $past(dm_wdata[cmc_pkg::BSEL_MODE_BIT]);
  endproperty
  a_mode_next: assert property (p_mode_next)
    else $error("mode bit not taken from write");
endmodule : cmc_core

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  typedef struct {
    logic [1:0] kind;
    int stamp;
    int lat;
    logic fault;
    logic [1:0] push;
    logic tbl;
    logic [15:0] ent;
    logic [12:0] pc;
    logic reg_en;
    logic mem_en;
  } cmc_note_t;

  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] dm_addr = 12'h000;
  logic dm_wr = 1'b0;
  logic [3:0] dm_wdata = 4'h0;
  logic op_valid = 1'b0;
  logic [2:0] op_code = 3'h0;
  logic [12:0] op_target = 13'h0000;
  logic irq_req = 1'b0;
  logic [2:0] irq_num = 3'h0;
  logic [7:0] pm_rdata;
  logic [3:0] dm_rdata;
  logic dm_ram_sel, dm_periph_sel, op_ready, op_busy, op_done, op_fault;
  logic [1:0] push_bytes;
  logic legacy_mode, stack_bank, start_valid, start_reg_bank_en;
  logic start_mem_bank_en;
  logic [12:0] pm_addr, start_pc;
  logic tbl_valid;
  logic [15:0] tbl_entry;
  logic [7:0] rom [0:4095];
  cmc_note_t notes [$];
  int miscompares = 0;
  int check_count = 0;
  int cyc = 0;

  always #5 mclk = ~mclk;
  always @(posedge mclk) cyc++;
  assign pm_rdata = rom[pm_addr[11:0]];

  cmc_core #(.PM_WORDS(4096)) dut (
    .mclk(mclk), .arst_n(arst_n), .dm_addr(dm_addr), .dm_wr(dm_wr),
    .dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .dm_ram_sel(dm_ram_sel),
    .dm_periph_sel(dm_periph_sel), .op_valid(op_valid),
    .op_code(op_code), .op_target(op_target), .irq_req(irq_req),
    .irq_num(irq_num), .pm_rdata(pm_rdata), .op_ready(op_ready),
    .op_busy(op_busy), .op_done(op_done), .op_fault(op_fault),
    .push_bytes(push_bytes), .legacy_mode(legacy_mode),
    .stack_bank(stack_bank), .pm_addr(pm_addr),
    .start_valid(start_valid), .start_pc(start_pc),
    .start_reg_bank_en(start_reg_bank_en),
    .start_mem_bank_en(start_mem_bank_en), .tbl_valid(tbl_valid),
    .tbl_entry(tbl_entry)
  );

  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic end_of_test;
    if (miscompares == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic wait_ready;
    int i;
    for (i = 0; i < 50 && op_ready !== 1'b1; i++)
      @(negedge mclk);
    if (op_ready !== 1'b1)
    begin
      miscompares++;
      end_of_test();
    end
  endtask : wait_ready

  function automatic cmc_note_t vec_note(input logic [12:0] a, input int l);
    cmc_note_t n;
    n = '{kind: 2'h1, stamp: cyc, lat: l, fault: 1'b0, push: 2'h0,
          tbl: 1'b0, ent: 16'h0000, pc: {rom[a][4:0], rom[a + 1]},
          reg_en: rom[a][6], mem_en: rom[a][7]};
    return n;
  endfunction : vec_note

  task automatic do_reset;
    int i;
    // Let running work report before it is cut off
    for (i = 0; i < 50 && notes.size() != 0; i++)
      @(negedge mclk);
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk("legacy_mode", legacy_mode, 1'b1);
    chk("stack_bank", stack_bank, 1'b0);
    chk("op_ready", op_ready, 1'b0);
    notes.push_back(vec_note(13'h0000, 0));
    @(posedge mclk);
    arst_n <= 1'b1;
  endtask : do_reset

  task automatic wr_reg(input logic [3:0] v);
    @(posedge mclk);
    dm_addr <= cmc_pkg::BSEL_ADDR;
    dm_wr <= 1'b1;
    dm_wdata <= v;
    @(posedge mclk);
    dm_wr <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    chk("bank_select", dm_rdata, v);
    chk("legacy_mode", legacy_mode, v[3]);
    chk("stack_bank", stack_bank, v[0]);
  endtask : wr_reg

  task automatic do_op(input logic [2:0] c, input logic [12:0] t);
    cmc_note_t n;
    logic leg;
    leg = legacy_mode;
    n = '{kind: 2'h0, stamp: 0, lat: 1, fault: 1'b1, push: 2'h0,
          tbl: 1'b0, ent: {rom[t[11:0]], rom[t[11:0] + 1]}, pc: 13'h0000,
          reg_en: 1'b0, mem_en: 1'b0};
    if (t < 13'h1000)
    begin
      n.fault = 1'b0;
      case (c)
        3'h0: n.lat = 1 + (leg ? cmc_pkg::CYC_CALL_LEG
                               : cmc_pkg::CYC_CALL_EXT);
        3'h1: n.lat = 1 + (leg ? cmc_pkg::CYC_FCALL_LEG
                               : cmc_pkg::CYC_FCALL_EXT);
        3'h2: n.lat = 1 + cmc_pkg::CYC_BR_FAR;
        3'h3: n.lat = 1 + cmc_pkg::CYC_CALL_FAR;
        3'h4: n.lat = 1 + cmc_pkg::CYC_RET;
        3'h5: n.lat = 4;
        default: n.fault = 1'b1;
      endcase
      if (leg && (c == 3'h2 || c == 3'h3))
        n.fault = 1'b1;
      if (c == 3'h5 && (t < 13'h0020 || t > 13'h007F))
        n.fault = 1'b1;
      if (n.fault)
        n.lat = 1;
      if (!n.fault && (c == 3'h0 || c == 3'h1 || c == 3'h3))
        n.push = leg ? 2'h2 : 2'h3;
      n.tbl = (c == 3'h5) && !n.fault;
    end
    @(posedge mclk);
    op_valid <= 1'b1;
    op_code <= c;
    op_target <= t;
    @(negedge mclk);
    wait_ready();
    n.stamp = cyc;
    notes.push_back(n);
    @(posedge mclk);
    op_valid <= 1'b0;
    @(negedge mclk);
    chk("op_busy", op_busy, !n.fault);
  endtask : do_op

  //////////////////////////////////////////////////////////////////////
  always @(negedge mclk)
  begin
    cmc_note_t n;
    if (start_valid === 1'b1 || op_done === 1'b1 || op_fault === 1'b1)
    begin
      if (notes.size() == 0)
      begin
        miscompares++;
        $display("MISMATCH result expected none seen one");
      end
      else
      begin
        n = notes.pop_front();
        if (n.lat != 0)
          chk("latency", cyc - n.stamp, n.lat);
        if (n.kind == 2'h1)
        begin
          chk("start", {start_valid, start_pc, start_reg_bank_en,
              start_mem_bank_en}, {1'b1, n.pc, n.reg_en, n.mem_en});
        end
        else
        begin
          chk("fault", {op_fault, op_done}, {n.fault, !n.fault});
          if (!n.fault)
            chk("push", push_bytes, n.push);
          if (n.tbl)
            chk("entry", {tbl_valid, tbl_entry}, {1'b1, n.ent});
        end
      end
    end
  end

  initial
  begin
    logic [11:0] sa [7];
    int i, c;
    void'($urandom(58770));
    for (i = 0; i < 4096; i++)
      rom[i] = 8'($urandom);
    sa = '{12'h000, 12'h1FF, 12'h200, 12'hF7F, 12'hF80, 12'hFFF, 12'hFC0};
    do_reset();
    wait_ready();
    foreach (sa[k])
    begin
      @(posedge mclk);
      dm_addr <= sa[k];
      @(posedge mclk);
      @(negedge mclk);
      chk("ram_sel", dm_ram_sel, sa[k] <= 12'h1FF);
      chk("periph_sel", dm_periph_sel, sa[k] >= 12'hF80);
    end
    for (i = 0; i < 2; i++)
    begin
      wr_reg({i[0], 2'b00, 1'($urandom)});
      for (c = 0; c < 8; c++)
        do_op(3'(c), (c == 5) ? 13'(32 + $urandom_range(95))
                              : 13'($urandom_range(4095)));
    end
    do_op(3'h5, 13'h001F);
    do_op(3'h5, 13'h0020);
    do_op(3'h5, 13'h007F);
    do_op(3'h5, 13'h0080);
    do_op(3'h0, 13'h1000);
    for (i = 0; i < 6; i++)
    begin
      @(posedge mclk);
      irq_req <= 1'b1;
      irq_num <= 3'(i);
      @(negedge mclk);
      wait_ready();
      notes.push_back(vec_note(13'(2 + 2 * i), 3));
      @(posedge mclk);
      irq_req <= 1'b0;
      @(negedge mclk);
      chk("pm_addr", pm_addr, 13'(2 + 2 * i));
    end
    wr_reg(4'h1);
    do_op(3'h1, 13'h0100);
    do_reset();
    for (i = 0; i < 50 && notes.size() != 0; i++)
      @(negedge mclk);
    chk("pending", notes.size(), 0);
    end_of_test();
  end
endmodule : tb_top
